//--- sim/acs_acquisition_settings_ctrl_tb.sv
module acs_acquisition_settings_ctrl_tb;
    import acs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_n, status_rd, reg_wr_en, reg_rd_en, quiet_mode_q, overrange_dis_q;
    logic motion_detect_enable, stillness_detect_enable, motion_event, stillness_event;
    logic motion_arm_q, stillness_arm_q, motion_pending_q, stillness_pending_q, wake_req_q;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rb;
    logic [2:0] lpf_cutoff_sel_q;
    logic last_p;
    bit ch, lp;
    int errors = 0;
    int samples_checked = 0;
    int np, nw;

    acs_acquisition_settings_ctrl DUT (.core_clk, .rst_n, .reg_addr, .reg_wr_en, .reg_rd_en,
        .reg_wdata, .reg_rdata_q, .status_rd, .motion_detect_enable,
        .stillness_detect_enable, .motion_event, .stillness_event, .motion_arm_q,
        .stillness_arm_q, .motion_pending_q, .stillness_pending_q, .wake_req_q,
        .lpf_cutoff_sel_q, .quiet_mode_q, .overrange_dis_q);
    acs_host_model host (.core_clk, .reg_rdata_q, .reg_addr, .reg_wdata, .reg_wr_en,
        .reg_rd_en, .status_rd);

    // 10 MHz clock
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // Pulse one detector, then count flag and wake cycles over five cycles
    task automatic fire(input bit still);
        @(negedge core_clk);
        motion_event = !still;
        stillness_event = still;
        np = 0;
        nw = 0;
        for (int k = 0; k < 5; k++) begin
            @(negedge core_clk);
            {motion_event, stillness_event} = 2'h0;
            last_p = still ? stillness_pending_q : motion_pending_q;
            np += (last_p === 1'h1);
            nw += (wake_req_q === 1'h1);
        end
    endtask : fire

    // Main sequence
    initial begin
        {rst_n, motion_detect_enable, stillness_detect_enable} = '0;
        {motion_event, stillness_event} = '0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'h1;
        host.rd(ACS_ADDR_ACQ_SETTINGS, rb);
        chk("reset value", ACS_ACQ_RESET, rb);
        // Every cutoff code; quiet shares bit 1 with the field
        for (int v = 0; v < 8; v++) begin
            host.wr(ACS_ADDR_ACQ_SETTINGS, 8'(v) | 8'h88);
            host.rd(ACS_ADDR_ACQ_SETTINGS, rb);
            chk("readback", 8'(v) | 8'h88, rb);
            chk("cutoff", (v > 4) ? 8'h04 : 8'(v), 8'(lpf_cutoff_sel_q));
            chk("quiet", 8'(v[1]), 8'(quiet_mode_q));
            chk("overrange", 8'h01, 8'(overrange_dis_q));
        end
        host.wr(8'h3D, 8'hFF);
        host.rd(8'h3D, rb);
        chk("unmapped", 8'h00, rb);
        host.rd(ACS_ADDR_ACQ_SETTINGS, rb);
        chk("kept", 8'h8F, rb);
        // All chaining codes, auto-doze off and on
        motion_detect_enable = 1'h1;
        stillness_detect_enable = 1'h1;
        for (int m = 0; m < 8; m++) begin
            lp = (m[2:1] == 2'h2);
            ch = lp || (m[2:1] == 2'h1);
            host.wr(ACS_ADDR_ACQ_SETTINGS, {1'h0, m[0], m[2:1], 4'h0});
            repeat (3) @(negedge core_clk);
            chk("still arm", 8'(!ch), 8'(stillness_arm_q));
            fire(1'h0);
            chk("motion flag", 8'(!lp), 8'(last_p));
            chk("motion arm", 8'(!ch), 8'(motion_arm_q));
            chk("flag cycles", lp ? 8'h01 : 8'h05, 8'(np));
            chk("motion wake", 8'h00, 8'(nw));
            fire(1'h1);
            chk("wake", 8'(ch && m[0]), 8'(nw));
            chk("still flag", 8'(!lp), 8'(last_p));
            host.ack();
            repeat (2) @(negedge core_clk);
            chk("acked", 8'h00, {6'h0, motion_pending_q, stillness_pending_q});
        end
        // Linked code with one enable missing falls back to default
        stillness_detect_enable = 1'h0;
        host.wr(ACS_ADDR_ACQ_SETTINGS, 8'h50);
        repeat (3) @(negedge core_clk);
        fire(1'h0);
        chk("arms", 8'h02, {6'h0, motion_arm_q, stillness_arm_q});
        test_done();
    end

    // Run is a few hundred cycles; wide margin
    initial begin
        #(5000 * 100);
        errors++;
        test_done();
    end
endmodule : acs_acquisition_settings_ctrl_tb

//--- sim/acs_host_model.sv
module acs_host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata_q,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic status_rd
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus idle at time zero
    initial begin
        {reg_addr, reg_wdata, reg_wr_en, reg_rd_en, status_rd} = '0;
    end

    // Released lines show inverted leftovers, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'h1;
        @(negedge core_clk);
        reg_wr_en = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // Read data taken once it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd_en = 1'h1;
        @(negedge core_clk);
        reg_rd_en = 1'h0;
        reg_addr = ~a;
        @(negedge core_clk);
        d = reg_rdata_q;
    endtask : rd

    // Status read acknowledges pending flags
    task automatic ack();
        @(negedge core_clk);
        status_rd = 1'h1;
        @(negedge core_clk);
        status_rd = 1'h0;
    endtask : ack
endmodule : acs_host_model

//--- src/acs_acquisition_settings_ctrl.sv
module acs_acquisition_settings_ctrl
    import acs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    input wire logic status_rd,
    input wire logic motion_detect_enable,
    input wire logic stillness_detect_enable,
    input wire logic motion_event,
    input wire logic stillness_event,
    output logic motion_arm_q,
    output logic stillness_arm_q,
    output logic motion_pending_q,
    output logic stillness_pending_q,
    output logic wake_req_q,
    output logic [2:0] lpf_cutoff_sel_q,
    output logic quiet_mode_q,
    output logic overrange_dis_q
);

    // Effective chaining: unknown code or missing enable falls back to default
    function automatic logic [1:0] eff_chain(input logic [1:0] code, input logic both_en);
        if (!both_en) begin
            eff_chain = ACS_CHAIN_DEFAULT;
        end else if (code == ACS_CHAIN_LINKED || code == ACS_CHAIN_LOOPED) begin
            eff_chain = code;
        end else begin
            eff_chain = ACS_CHAIN_DEFAULT;
        end
    endfunction : eff_chain

    // Saturate undefined cutoff codes to the widest filter
    function automatic logic [2:0] sat_bw(input logic [2:0] code);
        sat_bw = (code > ACS_BW_3200HZ) ? ACS_BW_3200HZ : code;
    endfunction : sat_bw

    logic [7:0] acq_q, acq_d;
    logic [7:0] rdata_d;
    acs_link_e link_q, link_d;
    logic motion_arm_d, stillness_arm_d;
    logic wake_d;
    logic [2:0] cutoff_d;
    logic quiet_d, ovr_d;
    logic [1:0] chain_eff;
    logic chained, looped;
    logic motion_hit, still_hit;
    logic hit_ack;

    assign chain_eff = eff_chain(acq_q[ACS_CHAIN_HI:ACS_CHAIN_LO],
                                 motion_detect_enable & stillness_detect_enable);
    assign chained = (chain_eff != ACS_CHAIN_DEFAULT);
    assign looped = (chain_eff == ACS_CHAIN_LOOPED);
    // Only an armed detector can report
    assign motion_hit = motion_event & motion_arm_q;
    assign still_hit = stillness_event & stillness_arm_q;
    assign hit_ack = status_rd & ~looped;

    // Register access; reading has no side effect
    always_comb begin
        acq_d = acq_q;
        rdata_d = reg_rdata_q;
        if (reg_wr_en && reg_addr == ACS_ADDR_ACQ_SETTINGS) begin
            acq_d = reg_wdata;
        end
        if (reg_rd_en) begin
            rdata_d = (reg_addr == ACS_ADDR_ACQ_SETTINGS) ? acq_q : 8'h00;
        end
    end

    // Decoded settings held in flops for the analog side
    always_comb begin
        cutoff_d = sat_bw(acq_q[ACS_BW_HI:ACS_BW_LO]);
        quiet_d = acq_q[ACS_BIT_QUIET];
        ovr_d = acq_q[ACS_BIT_OVERRANGE_DIS];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acq_q <= ACS_ACQ_RESET;
            reg_rdata_q <= 8'h00;
            lpf_cutoff_sel_q <= ACS_BW_200HZ;
            quiet_mode_q <= 1'h0;
            overrange_dis_q <= 1'h0;
        end else begin
            acq_q <= acq_d;
            reg_rdata_q <= rdata_d;
            lpf_cutoff_sel_q <= cutoff_d;
            quiet_mode_q <= quiet_d;
            overrange_dis_q <= ovr_d;
        end
    end

    // Detector sequencing; chained modes start by watching for motion
    always_comb begin
        link_d = link_q;
        case (link_q)
            ACS_WATCH_MOTION: begin
                if (chained && motion_hit) begin
                    link_d = ACS_WATCH_STILL;
                end
            end
            ACS_WATCH_STILL: begin
                if (!chained) begin
                    link_d = ACS_WATCH_MOTION;
                end else if (still_hit) begin
                    link_d = ACS_WATCH_MOTION;
                end
            end
            default: begin
                link_d = ACS_WATCH_MOTION;
            end
        endcase
        if (chained) begin
            motion_arm_d = (link_d == ACS_WATCH_MOTION);
            stillness_arm_d = (link_d == ACS_WATCH_STILL);
        end else begin
            motion_arm_d = motion_detect_enable;
            stillness_arm_d = stillness_detect_enable;
        end
        // Auto-doze only counts when chained
        wake_d = still_hit & chained & acq_q[ACS_BIT_AUTO_DOZE];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_q <= ACS_WATCH_MOTION;
            motion_arm_q <= 1'h0;
            stillness_arm_q <= 1'h0;
            wake_req_q <= 1'h0;
        end else begin
            link_q <= link_d;
            motion_arm_q <= motion_arm_d;
            stillness_arm_q <= stillness_arm_d;
            wake_req_q <= wake_d;
        end
    end

    // Looped mode acks in the cycle after the flag rises; host reads ack otherwise
    acs_pending_flag u_motion_flag (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .set_evt(motion_hit),
        .host_ack(hit_ack),
        .auto_ack(looped),
        .flag_q(motion_pending_q)
    );

    acs_pending_flag u_still_flag (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .set_evt(still_hit),
        .host_ack(hit_ack),
        .auto_ack(looped),
        .flag_q(stillness_pending_q)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_motion_seen_chained;
        chained && motion_hit && link_q == ACS_WATCH_MOTION;
    endsequence

    // Checked on the edge right after the hit: a stillness hit one cycle later may swap back
    sequence s_still_armed;
        link_q == ACS_WATCH_STILL && stillness_arm_q && !motion_arm_q;
    endsequence

    a_link_hands_over: assert property (
        s_motion_seen_chained |=> s_still_armed)
        else $error("Motion hit did not hand over to stillness watch");

    a_wake_on_still: assert property (
        still_hit && chained && acq_q[ACS_BIT_AUTO_DOZE] |=> wake_req_q)
        else $error("Wake-up request missing after stillness");

    a_wake_needs_chain: assert property (
        wake_req_q |-> $past(chained) && $past(acq_q[ACS_BIT_AUTO_DOZE]))
        else $error("Wake-up request without chaining or auto-doze");

    a_default_no_wake: assert property (
        !chained |=> !wake_req_q)
        else $error("Wake-up request in default arrangement");

    a_one_armed_chain: assert property (
        chained && $past(chained) |-> !(motion_arm_q && stillness_arm_q))
        else $error("Both detectors armed while chained");

    a_pending_holds: assert property (
        stillness_pending_q && !status_rd && !looped |=> stillness_pending_q)
        else $error("Pending flag dropped without a status read");

    a_loop_auto_ack: assert property (
        motion_pending_q && looped && !motion_hit |=> !motion_pending_q)
        else $error("Looped flag not cleared internally");

    a_half_enable_default: assert property (
        !(motion_detect_enable && stillness_detect_enable) |-> chain_eff == ACS_CHAIN_DEFAULT)
        else $error("Chaining applied without both enables");

    a_bw_saturate: assert property (
        $past(acq_q[ACS_BW_HI:ACS_BW_LO]) > ACS_BW_3200HZ |-> lpf_cutoff_sel_q == ACS_BW_3200HZ)
        else $error("Undefined cutoff code not saturated");

    a_write_store: assert property (
        reg_wr_en && reg_addr == ACS_ADDR_ACQ_SETTINGS |=> acq_q == $past(reg_wdata) ##1
        quiet_mode_q == acq_q[ACS_BIT_QUIET] || $past(reg_wr_en))
        else $error("Register write not stored or decoded");

    a_read_return: assert property (
        reg_rd_en && reg_addr == ACS_ADDR_ACQ_SETTINGS |=> reg_rdata_q == $past(acq_q))
        else $error("Register read returned wrong value");

endmodule : acs_acquisition_settings_ctrl

//--- src/acs_pending_flag.sv
module acs_pending_flag
    import acs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic set_evt,
    input wire logic host_ack,
    input wire logic auto_ack,
    output logic flag_q
);

    logic flag_d;

    // A new event in the acknowledge cycle keeps the flag up
    always_comb begin
        flag_d = set_evt | (flag_q & ~(host_ack | auto_ack));
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'h0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule : acs_pending_flag

//--- src/acs_pkg.sv
package acs_pkg;

    // Register map
    localparam logic [7:0] ACS_ADDR_ACQ_SETTINGS = 8'h3E;
    localparam logic [7:0] ACS_ACQ_RESET = 8'h00;

    // Field positions inside acquisition_settings
    localparam int ACS_BIT_OVERRANGE_DIS = 7;
    localparam int ACS_BIT_AUTO_DOZE = 6;
    localparam int ACS_CHAIN_HI = 5;
    localparam int ACS_CHAIN_LO = 4;
    localparam int ACS_BIT_QUIET = 1;
    localparam int ACS_BW_HI = 2;
    localparam int ACS_BW_LO = 0;

    // Activity chaining codes
    localparam logic [1:0] ACS_CHAIN_DEFAULT = 2'h0;
    localparam logic [1:0] ACS_CHAIN_LINKED = 2'h1;
    localparam logic [1:0] ACS_CHAIN_LOOPED = 2'h2;

    // Cutoff codes: 200, 400, 800, 1600, 3200 Hz
    localparam logic [2:0] ACS_BW_200HZ = 3'h0;
    localparam logic [2:0] ACS_BW_3200HZ = 3'h4;

    // Which detector is armed while chained
    typedef enum logic [0:0] {
        ACS_WATCH_MOTION = 1'h0,
        ACS_WATCH_STILL = 1'h1
    } acs_link_e;

endpackage : acs_pkg
